//--- hdl/line_event_pkg.sv
// constants for the edge line event unit
// Function
// - line interrupt passes only while its interrupt mask bit is set
// - line event pulse passes only while its event mask bit is set
// - rising select bit makes a low-to-high change a request
// - falling select bit makes a high-to-low change a request; both give either edge
// - writing one to a soft trigger bit that is zero raises a request; zero deactivates it
// - pending flag is sticky, cleared only by writing one
// - sixteen pin lines plus supply monitor, alarm and usb wakeup lines
// - each line configured and masked independently of the others
`default_nettype none
package line_event_pkg;
	localparam int          NUM_LINES        = 19;
	localparam int          NUM_PIN_LINES    = 16;
	localparam int          PIN_SEL_W        = 2;
	localparam int          SYNC_STAGES      = 2;
	localparam logic [7:0]  OFS_INT_MASK     = 8'h00;
	localparam logic [7:0]  OFS_EVT_MASK     = 8'h04;
	localparam logic [7:0]  OFS_RISE_SEL     = 8'h08;
	localparam logic [7:0]  OFS_FALL_SEL     = 8'h0C;
	localparam logic [7:0]  OFS_SOFT_TRIG    = 8'h10;
	localparam logic [7:0]  OFS_PENDING      = 8'h14;
	localparam logic [7:0]  OFS_PIN_SEL_LO   = 8'h18;
	localparam logic [7:0]  OFS_PIN_SEL_HI   = 8'h1C;
	localparam logic [18:0] RST_LINE_REG     = 19'h00000;
	localparam logic [31:0] RST_PIN_SEL      = 32'h00000000;
	localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
	localparam logic [1:0]  HTRANS_SEQ       = 2'h3;
	localparam logic [1:0]  HRESP_OKAY       = 2'h0;
endpackage : line_event_pkg
`default_nettype wire

//--- hdl/line_edge_detect.sv
// per line synchroniser and edge detector
`timescale 1ns/1ps
`default_nettype none
module line_edge_detect (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic line_in,
	input  wire logic rise_en,
	input  wire logic fall_en,
	output logic      trigger
);
	import line_event_pkg::*;

	logic [SYNC_STAGES-1:0] sync_q;
	logic [SYNC_STAGES-1:0] next_sync_q;
	logic                   prev_q;
	logic                   next_prev_q;
	logic                   trig_q;
	logic                   next_trig_q;
	logic                   cur;

	always_comb begin
		next_sync_q = {sync_q[SYNC_STAGES-2:0], line_in};
		cur         = sync_q[SYNC_STAGES-1];
		next_prev_q = cur;
		next_trig_q = (rise_en & cur & ~prev_q)
			| (fall_en & ~cur & prev_q);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_q <= '0;
			prev_q <= 1'b0;
			trig_q <= 1'b0;
		end else begin
			sync_q <= next_sync_q;
			prev_q <= next_prev_q;
			trig_q <= next_trig_q;
		end
	end

	assign trigger = trig_q;
endmodule : line_edge_detect
`default_nettype wire

//--- hdl/edge_line_event_unit.sv
// edge line event unit with ahb-lite register slave
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module edge_line_event_unit (
	input  wire logic                                     hclk,
	input  wire logic                                     hresetn,
	input  wire logic                                     hsel,
	input  wire logic [31:0]                              haddr,
	input  wire logic [1:0]                               htrans,
	input  wire logic                                     hwrite,
	input  wire logic [2:0]                               hsize,
	input  wire logic                                     hready,
	input  wire logic [31:0]                              hwdata,
	output logic      [31:0]                              hrdata,
	output logic                                          hreadyout,
	output logic      [1:0]                               hresp,
	input  wire logic [line_event_pkg::NUM_PIN_LINES-1:0] port_a_pins,
	input  wire logic [line_event_pkg::NUM_PIN_LINES-1:0] port_b_pins,
	input  wire logic [line_event_pkg::NUM_PIN_LINES-1:0] port_c_pins,
	input  wire logic [line_event_pkg::NUM_PIN_LINES-1:0] port_d_pins,
	input  wire logic                                     supply_monitor_detect,
	input  wire logic                                     alarm_line,
	input  wire logic                                     usb_wakeup_line,
	output logic      [line_event_pkg::NUM_LINES-1:0]     line_irq,
	output logic      [line_event_pkg::NUM_LINES-1:0]     line_event
);
	import line_event_pkg::*;

	logic [NUM_LINES-1:0] line_interrupt_mask;
	logic [NUM_LINES-1:0] line_event_mask;
	logic [NUM_LINES-1:0] rising_edge_select;
	logic [NUM_LINES-1:0] falling_edge_select;
	logic [NUM_LINES-1:0] software_trigger;
	logic [NUM_LINES-1:0] line_pending_flags;
	logic [31:0]          pin_select;
	logic [NUM_LINES-1:0] next_line_interrupt_mask;
	logic [NUM_LINES-1:0] next_line_event_mask;
	logic [NUM_LINES-1:0] next_rising_edge_select;
	logic [NUM_LINES-1:0] next_falling_edge_select;
	logic [NUM_LINES-1:0] next_software_trigger;
	logic [NUM_LINES-1:0] next_line_pending_flags;
	logic [31:0]          next_pin_select;
	logic                 wr_pend;
	logic [7:0]           wr_addr;
	logic                 next_wr_pend;
	logic [7:0]           next_wr_addr;
	logic [31:0]          rdata;
	logic [31:0]          next_rdata;
	logic [NUM_LINES-1:0] src_line;
	logic [NUM_LINES-1:0] edge_trig;
	logic [NUM_LINES-1:0] soft_pulse;
	logic [NUM_LINES-1:0] req;
	logic [NUM_LINES-1:0] irq_q;
	logic [NUM_LINES-1:0] evt_q;
	logic [NUM_LINES-1:0] next_irq_q;
	logic [NUM_LINES-1:0] next_evt_q;
	logic                 addr_phase;
	logic [NUM_LINES-1:0] wmask;

	// line sources: pins by selected port, then internal sources
	genvar g;
	generate
		for (g = 0; g < NUM_LINES; g++) begin : g_line
			if (g < NUM_PIN_LINES) begin : g_pin
				logic [PIN_SEL_W-1:0] sel;
				assign sel = pin_select[g*PIN_SEL_W +: PIN_SEL_W];
				assign src_line[g] = (sel == 2'h0) ? port_a_pins[g] :
					(sel == 2'h1) ? port_b_pins[g] :
					(sel == 2'h2) ? port_c_pins[g] : port_d_pins[g];
			end
			line_edge_detect u_det (
				.hclk    (hclk),
				.hresetn (hresetn),
				.line_in (src_line[g]),
				.rise_en (rising_edge_select[g]),
				.fall_en (falling_edge_select[g]),
				.trigger (edge_trig[g])
			);
		end
	endgenerate
	assign src_line[16] = supply_monitor_detect;
	assign src_line[17] = alarm_line;
	assign src_line[18] = usb_wakeup_line;

	always_comb begin
		addr_phase = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
		next_wr_pend = addr_phase & hwrite;
		next_wr_addr = haddr[7:0];
		wmask = hwdata[NUM_LINES-1:0];
		soft_pulse = '0;
		next_line_interrupt_mask = line_interrupt_mask;
		next_line_event_mask = line_event_mask;
		next_rising_edge_select = rising_edge_select;
		next_falling_edge_select = falling_edge_select;
		next_software_trigger = software_trigger;
		next_pin_select = pin_select;
		next_line_pending_flags = line_pending_flags;
		if (wr_pend) begin
			unique case (wr_addr)
				OFS_INT_MASK:   next_line_interrupt_mask = wmask;
				OFS_EVT_MASK:   next_line_event_mask = wmask;
				OFS_RISE_SEL:   next_rising_edge_select = wmask;
				OFS_FALL_SEL:   next_falling_edge_select = wmask;
				OFS_SOFT_TRIG: begin
					next_software_trigger = wmask;
					soft_pulse = wmask & ~software_trigger;
				end
				OFS_PENDING:    next_line_pending_flags = line_pending_flags & ~wmask;
				OFS_PIN_SEL_LO: next_pin_select = hwdata;
				OFS_PIN_SEL_HI: next_pin_select = hwdata;
				default: ;
			endcase
		end
		req = edge_trig | soft_pulse;
		next_line_pending_flags = next_line_pending_flags | req;
		next_irq_q = req & line_interrupt_mask;
		next_evt_q = req & line_event_mask;
		next_rdata = 32'h00000000;
		if (addr_phase && !hwrite) begin
			unique case (haddr[7:0])
				OFS_INT_MASK:   next_rdata = {13'h0000, line_interrupt_mask};
				OFS_EVT_MASK:   next_rdata = {13'h0000, line_event_mask};
				OFS_RISE_SEL:   next_rdata = {13'h0000, rising_edge_select};
				OFS_FALL_SEL:   next_rdata = {13'h0000, falling_edge_select};
				OFS_SOFT_TRIG:  next_rdata = {13'h0000, software_trigger};
				OFS_PENDING:    next_rdata = {13'h0000, line_pending_flags};
				OFS_PIN_SEL_LO: next_rdata = pin_select;
				OFS_PIN_SEL_HI: next_rdata = pin_select;
				default:        next_rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			line_interrupt_mask <= RST_LINE_REG;
			line_event_mask <= RST_LINE_REG;
			rising_edge_select <= RST_LINE_REG;
			falling_edge_select <= RST_LINE_REG;
			software_trigger <= RST_LINE_REG;
			line_pending_flags <= RST_LINE_REG;
			pin_select <= RST_PIN_SEL;
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			rdata <= 32'h00000000;
			irq_q <= RST_LINE_REG;
			evt_q <= RST_LINE_REG;
		end else begin
			line_interrupt_mask <= next_line_interrupt_mask;
			line_event_mask <= next_line_event_mask;
			rising_edge_select <= next_rising_edge_select;
			falling_edge_select <= next_falling_edge_select;
			software_trigger <= next_software_trigger;
			line_pending_flags <= next_line_pending_flags;
			pin_select <= next_pin_select;
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			rdata <= next_rdata;
			irq_q <= next_irq_q;
			evt_q <= next_evt_q;
		end
	end

	assign hrdata = rdata;
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;
	assign line_irq = irq_q;
	assign line_event = evt_q;
endmodule : edge_line_event_unit
`default_nettype wire

//--- sim/line_event_props.sv
// assertion checker for the edge line event unit
`timescale 1ns/1ps
`default_nettype none
module line_event_props (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic [1:0]  hresp,
	input wire logic        supply_monitor_detect,
	input wire logic [18:0] line_irq,
	input wire logic [18:0] line_event
);
	logic       rd_ph;
	logic [7:0] rd_a;
	logic [5:0] smd_h;
	logic [2:0] wr_h;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	always_ff @(posedge hclk) begin
		rd_ph <= hsel && htrans[1] && !hwrite;
		rd_a <= haddr[7:0];
		smd_h <= {smd_h[4:0], supply_monitor_detect};
		wr_h <= {wr_h[1:0], hsel && htrans[1] && hwrite};
	end
	a_quiet_reset: assert property ($rose(hresetn) |-> (line_irq == 19'h0 && line_event == 19'h0)[*2])
		else $error("pulse right after reset");
	a_irq_single: assert property ((line_irq & $past(line_irq)) == 19'h0)
		else $error("irq longer than one cycle");
	a_evt_single: assert property ((line_event & $past(line_event)) == 19'h0)
		else $error("event longer than one cycle");
	a_irq_cause: assert property (line_irq[16] |-> (smd_h != 6'h00 && smd_h != 6'h3F) || wr_h != 3'h0)
		else $error("irq without edge or write");
	a_unmapped_zero: assert property (rd_ph && rd_a > 8'h1C |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_reserved_zero: assert property (rd_ph && rd_a < 8'h18 |-> hrdata[31:19] == 13'h0)
		else $error("reserved bits not zero");
	a_bus_ready: assert property (hreadyout)
		else $error("wait state inserted");
	a_resp_okay: assert property (hresp == 2'h0)
		else $error("response not okay");
	cover property (line_irq[16]);
	cover property (line_event != 19'h0);
	cover property (rd_ph && rd_a == 8'h14 && hrdata != 32'h0);
endmodule : line_event_props
bind edge_line_event_unit line_event_props u_line_event_props (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .supply_monitor_detect(supply_monitor_detect),
	.line_irq(line_irq), .line_event(line_event));
`default_nettype wire

//--- sim/line_irq_sink.sv
// processor side model counting irq and event pulses
`timescale 1ns/1ps
`default_nettype none
module line_irq_sink (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic [18:0] line_irq,
	input wire logic [18:0] line_event,
	output var int          irq_cnt,
	output var int          evt_cnt
);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_cnt <= 0;
			evt_cnt <= 0;
		end else begin
			irq_cnt <= irq_cnt + $countones(line_irq);
			evt_cnt <= evt_cnt + $countones(line_event);
		end
	end
endmodule : line_irq_sink
`default_nettype wire

//--- sim/edge_line_event_controller_tb_top.sv
// testbench for the edge line event unit
`timescale 1ns/1ps
`default_nettype none
module edge_line_event_controller_tb_top;
	import line_event_pkg::*;
	`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
	logic        hclk, hresetn, hsel, hwrite, hreadyout, smd, alarm, usb;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0]  htrans, hresp;
	logic [15:0] pa, pb, pc, pd;
	logic [18:0] irq, evt;
	int          irq_cnt, evt_cnt, fail_count, n_tests;
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	edge_line_event_unit u_edge_line_event_unit (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.port_a_pins(pa), .port_b_pins(pb), .port_c_pins(pc), .port_d_pins(pd),
		.supply_monitor_detect(smd), .alarm_line(alarm), .usb_wakeup_line(usb),
		.line_irq(irq), .line_event(evt));
	line_irq_sink u_line_irq_sink (.hclk(hclk), .hresetn(hresetn), .line_irq(irq),
		.line_event(evt), .irq_cnt(irq_cnt), .evt_cnt(evt_cnt));
	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : complete_run
	task automatic wt();
		for (int i = 0; i < 20; i++) begin
			@(posedge hclk);
			if (hreadyout === 1'b1) return;
		end
		fail_count++;
		complete_run();
	endtask : wt
	task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		wt();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wt();
		q = hrdata;
	endtask : xf
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xf(1'b0, a, 32'h0);
		`CHK(q, e)
	endtask : rd
	initial begin
		hresetn = 1'b0;
		{hsel, hwrite, smd, alarm, usb} = 5'h00;
		{haddr, hwdata, htrans} = 66'h0;
		{pa, pb, pc, pd} = 64'h0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		for (int o = 0; o < 24; o += 4) rd(o[7:0], 32'h0);
		xf(1'b1, OFS_INT_MASK, 32'hFFFFFFFF);
		rd(OFS_INT_MASK, 32'h0007FFFF);
		xf(1'b1, OFS_INT_MASK, 32'h00050000);
		xf(1'b1, OFS_EVT_MASK, 32'h00020000);
		xf(1'b1, OFS_RISE_SEL, 32'h00030008);
		smd <= 1'b1;
		repeat (6) @(posedge hclk);
		smd <= 1'b0;
		repeat (6) @(posedge hclk);
		`CHK(irq_cnt, 1)
		`CHK(evt_cnt, 0)
		rd(OFS_PENDING, 32'h00010000);
		xf(1'b1, OFS_PENDING, 32'h0);
		rd(OFS_PENDING, 32'h00010000);
		xf(1'b1, OFS_PENDING, 32'h00010000);
		rd(OFS_PENDING, 32'h0);
		xf(1'b1, OFS_FALL_SEL, 32'h00010000);
		smd <= 1'b1;
		repeat (6) @(posedge hclk);
		smd <= 1'b0;
		alarm <= 1'b1;
		repeat (6) @(posedge hclk);
		`CHK(irq_cnt, 3)
		`CHK(evt_cnt, 1)
		xf(1'b1, OFS_SOFT_TRIG, 32'h00040000);
		repeat (4) @(posedge hclk);
		`CHK(irq_cnt, 4)
		rd(OFS_SOFT_TRIG, 32'h00040000);
		xf(1'b1, OFS_PIN_SEL_LO, 32'h00000080);
		pa <= 16'h0008;
		repeat (6) @(posedge hclk);
		rd(OFS_PENDING, 32'h00070000);
		pc <= 16'h0008;
		repeat (6) @(posedge hclk);
		rd(OFS_PENDING, 32'h00070008);
		`CHK(irq_cnt, 4)
		xf(1'b1, OFS_PENDING, 32'h0007FFFF);
		rd(OFS_PENDING, 32'h0);
		xf(1'b1, OFS_PIN_SEL_HI, 32'h00000040);
		rd(OFS_PIN_SEL_LO, 32'h00000040);
		pb <= 16'h0008;
		repeat (6) @(posedge hclk);
		rd(OFS_PENDING, 32'h00000008);
		xf(1'b1, OFS_SOFT_TRIG, 32'h0);
		xf(1'b1, OFS_SOFT_TRIG, 32'h00040000);
		repeat (4) @(posedge hclk);
		`CHK(irq_cnt, 5)
		rd(8'h20, 32'h0);
		complete_run();
	end
endmodule : edge_line_event_controller_tb_top
`default_nettype wire
